/* rtl/pmc_defs.svh */
// constants for the power mode controller
// Behaviour
// [RQ1] chip held in reset while supply monitor reports supply below threshold
// [RQ2] idle-select write halts cpu once the writing instruction completes
// [RQ3] idle keeps registers, memory and peripherals running
// [RQ4] enabled interrupt in idle clears idle-select and restarts cpu
// [RQ5] after interrupt return, execution continues after the idle-selecting instruction
// [RQ6] reset ending idle or stop runs reset sequence, fetch from 0x0000
// [RQ7] wake from idle or low power idle within 2 clock cycles
// [RQ8] stop-select halts cpu and precision oscillator, other oscillators untouched
// [RQ9] stop ends only through reset, never by interrupt
// [RQ10] suspend-select gates system clock and disables internal oscillators until wake
// [RQ11] suspend wake: rtc fail, rtc alarm, port match, i2c match, touch sense, reset pin
// [RQ12] wake from suspend or sleep resumes at next instruction, no reset
// [RQ13] sleep-select turns off core regulator, ram on vdd, only pmu and rtc powered
// [RQ14] sleep wake: rtc fail, rtc alarm, port match, i2c match; code also wakes sleep on reset pin
// [RQ15] sleep preserves ram, registers, program counter above por threshold
// [RQ16] firmware should disable analog peripherals before sleep
// [RQ17] low power active gates peripheral branches; gated registers not accessible; code also clocks requesting gated branches in low power active
// [RQ18] low power active ends when gating register written 0x00 or reset
// [RQ19] low power idle halts cpu; requesting peripherals get their clock
// [RQ20] interrupt in low power idle returns to low power active only
// [RQ21] reset ending low power idle runs reset sequence from 0x0000
// [RQ22] each wake source ends suspend or sleep only when individually enabled
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_RESET_VECTOR   16'h0000
`define PMC_GATE_NONE      8'h00
`define PMC_WAKE_CYCLES    2
`define PMC_WK_RTC_FAIL    0
`define PMC_WK_RTC_ALARM   1
`define PMC_WK_PORT_MATCH  2
`define PMC_WK_I2C_MATCH   3
`define PMC_WK_TOUCH       4
`define PMC_WK_RST_PIN     5
`define PMC_SLEEP_WAKE_MSK 6'h2f
`define PMC_SUSP_WAKE_MSK  6'h3f
`endif

/* rtl/pmc_pkg.sv */
// types for the power mode controller
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_ACTIVE  = 3'b000,
    PMC_IDLE    = 3'b001,
    PMC_STOP    = 3'b010,
    PMC_SUSPEND = 3'b011,
    PMC_SLEEP   = 3'b100
  } pmc_state_t;
endpackage : pmc_pkg

/* rtl/pmc_power_mode_controller.sv */
// power mode sequencer: modes, clock gating, wake and reset control
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NBR = 8
)(
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           supply_monitor_low,
  input  wire logic           reset_pin_n,
  input  wire logic           cpu_instr_done,
  input  wire logic           idle_sel_wr,
  input  wire logic           stop_sel_wr,
  input  wire logic           suspend_sel_wr,
  input  wire logic           sleep_sel_wr,
  input  wire logic           gate_wr,
  input  wire logic [NBR-1:0] gate_wdata,
  input  wire logic           int_pending,
  input  wire logic           internal_reset,
  input  wire logic [5:0]     wake_enable,
  input  wire logic [5:0]     wake_event,
  input  wire logic [NBR-1:0] periph_clk_req,
  output logic                chip_reset,
  output logic [15:0]         fetch_addr_load,
  output logic                cpu_halt,
  output logic                idle_sel,
  output logic                sysclk_gate,
  output logic                precision_osc_en,
  output logic                internal_osc_en,
  output logic                core_regulator_en,
  output logic                ram_on_vdd,
  output logic                lp_active,
  output logic [NBR-1:0]      periph_clk_en,
  output logic [NBR-1:0]      sfr_access_en
);
  // ************************************************
  // input synchronisers
  // ************************************************
  logic       mon_s1_q;
  logic       mon_s2_q;
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic [5:0] wk_s1_q;
  logic [5:0] wk_s2_q;

  // supply flag: only the second flop feeds the reset logic
  always_ff @(posedge mclk)
  begin
    mon_s1_q <= supply_monitor_low;
    mon_s2_q <= mon_s1_q;
  end

  // pin is inverted on entry so that high means reset requested
  always_ff @(posedge mclk)
  begin
    pin_s1_q <= ~reset_pin_n;
    pin_s2_q <= pin_s1_q;
  end

  // wake events are levels, so bitwise syncing is safe
  always_ff @(posedge mclk)
  begin
    wk_s1_q <= wake_event;
    wk_s2_q <= wk_s1_q;
  end

  // ************************************************
  // mode state
  // ************************************************
  pmc_state_t     st_q;
  pmc_state_t     st_d;
  logic           pend_idle_q;
  logic           pend_idle_d;
  logic           pend_stop_q;
  logic           pend_stop_d;
  logic           pend_susp_q;
  logic           pend_susp_d;
  logic           pend_sleep_q;
  logic           pend_sleep_d;
  logic [NBR-1:0] gate_q;
  logic [NBR-1:0] gate_d;
  logic           any_reset;
  logic [5:0]     wake_raw;
  logic [5:0]     wake_live;
  logic           susp_wake;
  logic           sleep_wake;
  logic           pin_is_reset;

  // ************************************************
  // wake and reset decode
  // ************************************************
  // reset pin is a wake source in suspend and sleep, a reset everywhere else
  always_comb
  begin
    wake_raw     = {pin_s2_q, wk_s2_q[4:0]};
    wake_live    = wake_raw & wake_enable;                         // RQ22
    susp_wake    = |(wake_live & `PMC_SUSP_WAKE_MSK);              // RQ11
    sleep_wake   = |(wake_live & `PMC_SLEEP_WAKE_MSK);             // RQ14
    pin_is_reset = pin_s2_q & (st_q != PMC_SUSPEND) & (st_q != PMC_SLEEP);
    any_reset    = rst | mon_s2_q | internal_reset | pin_is_reset; // RQ1 RQ6 RQ21
  end

  // ************************************************
  // clock-gating mode register
  // ************************************************
  // reset wins over a write in the same cycle
  always_comb
  begin
    gate_d = gate_q;
    if (any_reset)
      gate_d = {NBR{1'b0}};                         // RQ18
    else if (gate_wr)
      gate_d = gate_wdata;                          // RQ17 RQ18
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      gate_q <= {NBR{1'b0}};
    else
      gate_q <= gate_d;
  end

  // ************************************************
  // mode next state
  // ************************************************
  always_comb
  begin
    st_d         = st_q;
    pend_idle_d  = pend_idle_q | idle_sel_wr;
    pend_stop_d  = pend_stop_q | stop_sel_wr;
    pend_susp_d  = pend_susp_q | suspend_sel_wr;
    pend_sleep_d = pend_sleep_q | sleep_sel_wr;
    case (st_q)
      PMC_ACTIVE:
      begin
        // entry waits for the selecting instruction to retire
        if (cpu_instr_done)
        begin
          if (pend_sleep_d)
            st_d = PMC_SLEEP;                       // RQ13
          else if (pend_susp_d)
            st_d = PMC_SUSPEND;                     // RQ10
          else if (pend_stop_d)
            st_d = PMC_STOP;                        // RQ8
          else if (pend_idle_d)
            st_d = PMC_IDLE;                        // RQ2 RQ19
          pend_idle_d  = 1'b0;
          pend_stop_d  = 1'b0;
          pend_susp_d  = 1'b0;
          pend_sleep_d = 1'b0;
        end
      end
      PMC_IDLE:
        if (int_pending)
          st_d = PMC_ACTIVE;                        // RQ4 RQ5 RQ7 RQ20
      PMC_STOP:
        st_d = PMC_STOP;                            // RQ9
      PMC_SUSPEND:
        if (susp_wake)
          st_d = PMC_ACTIVE;                        // RQ11 RQ12
      PMC_SLEEP:
        if (sleep_wake)
          st_d = PMC_ACTIVE;                        // RQ14 RQ12 RQ15
      default:
        st_d = PMC_ACTIVE;
    endcase
    if (any_reset)
    begin
      st_d         = PMC_ACTIVE;                    // RQ1 RQ6 RQ21
      pend_idle_d  = 1'b0;
      pend_stop_d  = 1'b0;
      pend_susp_d  = 1'b0;
      pend_sleep_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q         <= PMC_ACTIVE;
      pend_idle_q  <= 1'b0;
      pend_stop_q  <= 1'b0;
      pend_susp_q  <= 1'b0;
      pend_sleep_q <= 1'b0;
    end
    else
    begin
      st_q         <= st_d;
      pend_idle_q  <= pend_idle_d;
      pend_stop_q  <= pend_stop_d;
      pend_susp_q  <= pend_susp_d;
      pend_sleep_q <= pend_sleep_d;
    end
  end

  // ************************************************
  // registered outputs
  // ************************************************
  logic           rst_o_d;
  logic           halt_d;
  logic           idle_d;
  logic           gate_o_d;
  logic           posc_d;
  logic           iosc_d;
  logic           reg_d;
  logic           ram_d;
  logic           lpa_d;
  logic [NBR-1:0] pclk_d;
  logic [NBR-1:0] sfr_d;

  // decoded from the next state so outputs move on the same edge as the mode
  always_comb
  begin
    rst_o_d  = any_reset;                           // RQ1
    halt_d   = 1'b0;
    idle_d   = 1'b0;
    gate_o_d = 1'b0;
    posc_d   = 1'b1;
    iosc_d   = 1'b1;
    reg_d    = 1'b1;
    ram_d    = 1'b0;
    case (st_d)
      PMC_ACTIVE:
      begin
        halt_d = 1'b0;
      end
      PMC_IDLE:
      begin
        // idle keeps every peripheral clock, lp idle only ungated or requesting ones; only the cpu halts
        halt_d = 1'b1;                              // RQ2 RQ19 RQ3
        idle_d = 1'b1;                              // RQ4
      end
      PMC_STOP:
      begin
        halt_d = 1'b1;                              // RQ8
        posc_d = 1'b0;                              // RQ8
      end
      PMC_SUSPEND:
      begin
        halt_d   = 1'b1;
        gate_o_d = 1'b1;                            // RQ10
        posc_d   = 1'b0;
        iosc_d   = 1'b0;                            // RQ10
      end
      PMC_SLEEP:
      begin
        halt_d   = 1'b1;
        gate_o_d = 1'b1;
        posc_d   = 1'b0;
        iosc_d   = 1'b0;
        reg_d    = 1'b0;                            // RQ13
        ram_d    = 1'b1;                            // RQ13
      end
      default:
      begin
        halt_d = 1'b0;
      end
    endcase
    lpa_d = (gate_d != `PMC_GATE_NONE);             // RQ18 RQ20
    if (gate_o_d)
      pclk_d = {NBR{1'b0}};
    else
      pclk_d = ~gate_d | periph_clk_req;            // RQ19
    sfr_d = ~gate_d;                                // RQ17
  end

  // ************************************************
  // cpu facing outputs
  // ************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      chip_reset        <= 1'b1;
      fetch_addr_load   <= `PMC_RESET_VECTOR;
      cpu_halt          <= 1'b0;
      idle_sel          <= 1'b0;
    end
    else
    begin
      chip_reset        <= rst_o_d;                 // RQ6
      fetch_addr_load   <= `PMC_RESET_VECTOR;       // RQ6 RQ21
      cpu_halt          <= halt_d;
      idle_sel          <= idle_d;                  // RQ4
    end
  end

  // ************************************************
  // clock and power outputs
  // ************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sysclk_gate       <= 1'b0;
      precision_osc_en  <= 1'b1;
      internal_osc_en   <= 1'b1;
      core_regulator_en <= 1'b1;
      ram_on_vdd        <= 1'b0;
      lp_active         <= 1'b0;
      periph_clk_en     <= {NBR{1'b1}};
      sfr_access_en     <= {NBR{1'b1}};
    end
    else
    begin
      sysclk_gate       <= gate_o_d;
      precision_osc_en  <= posc_d;
      internal_osc_en   <= iosc_d;
      core_regulator_en <= reg_d;
      ram_on_vdd        <= ram_d;
      lp_active         <= lpa_d;
      periph_clk_en     <= pclk_d;
      sfr_access_en     <= sfr_d;
    end
  end
endmodule : pmc_power_mode_controller

/* bench/pmc_cpu_model.sv */
// cpu and firmware stand-in that retires the select-writing instruction
`timescale 1ns/1ps
module pmc_cpu_model (
  input  wire logic mclk,
  input  wire logic slow,
  input  wire logic sel_wr,
  output logic      instr_done
);
  logic sel_q;
  // slow retires one cycle late, so entry must wait for retirement
  always_ff @(posedge mclk) sel_q <= sel_wr;
  assign instr_done = slow ? sel_q : sel_wr;
endmodule : pmc_cpu_model

/* bench/pmc_power_mode_controller_monitor.sv */
// port assertions for the power mode controller
`timescale 1ns/1ps
module pmc_power_mode_controller_monitor #(parameter int NBR = 8) (
  input wire logic mclk, rst, supply_monitor_low, cpu_instr_done, idle_sel_wr, stop_sel_wr, sleep_sel_wr,
  input wire logic gate_wr, int_pending, chip_reset, cpu_halt, idle_sel, sysclk_gate, precision_osc_en,
  input wire logic core_regulator_en, ram_on_vdd, lp_active,
  input wire logic [NBR-1:0] gate_wdata,
  input wire logic [5:0] wake_enable
);
  // ****
  // properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // async supply flag passes two sync flops before the reset register
  property p_sup; supply_monitor_low |-> ##[1:4] chip_reset; endproperty
  a_sup: assert property (p_sup) else $error("no reset on low supply");
  sequence s_idle; idle_sel_wr && cpu_instr_done && !int_pending && !chip_reset; endsequence
  property p_idle; s_idle |-> ##[1:2] (cpu_halt && idle_sel); endproperty
  a_idle: assert property (p_idle) else $error("idle not entered");
  property p_wake; idle_sel && int_pending |-> ##[1:2] (!cpu_halt && !idle_sel); endproperty
  a_wake: assert property (p_wake) else $error("idle wake late");
  property p_stop; stop_sel_wr && cpu_instr_done |-> ##[1:2] (cpu_halt && !precision_osc_en); endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");
  // suspend and sleep excluded: they may wake on events
  property p_hold;
    cpu_halt && !precision_osc_en && !sysclk_gate && core_regulator_en |=> cpu_halt || chip_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("stop left without reset");
  property p_sleep; sleep_sel_wr && cpu_instr_done |-> ##[1:2] (!core_regulator_en && ram_on_vdd); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep power not cut");
  property p_gate; gate_wr |=> lp_active == ($past(gate_wdata) != 8'h00); endproperty
  a_gate: assert property (p_gate) else $error("gating mode wrong");
  property p_ign; sysclk_gate && wake_enable == 6'h00 |=> sysclk_gate || chip_reset; endproperty
  a_ign: assert property (p_ign) else $error("woke with no source enabled");
endmodule : pmc_power_mode_controller_monitor
bind pmc_power_mode_controller pmc_power_mode_controller_monitor #(.NBR(NBR)) u_mon (.*);

/* bench/tb.sv */
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  logic mclk = 0, rst = 1, supply_monitor_low = 0, reset_pin_n = 1, idle_sel_wr = 0, stop_sel_wr = 0, slow = 0;
  logic suspend_sel_wr = 0, sleep_sel_wr = 0, gate_wr = 0, int_pending = 0, internal_reset = 0, cpu_instr_done;
  logic [7:0] gate_wdata = 8'h00, periph_clk_req = 8'h00, periph_clk_en, sfr_access_en;
  logic [5:0] wake_enable = 6'h00, wake_event = 6'h00;
  logic [15:0] fetch_addr_load;
  logic chip_reset, cpu_halt, idle_sel, sysclk_gate, precision_osc_en, internal_osc_en, core_regulator_en;
  logic ram_on_vdd, lp_active;
  int mismatches = 0, compares = 0;
  always #4 mclk = ~mclk;
  pmc_power_mode_controller u_pmc_power_mode_controller (.*);
  pmc_cpu_model u_pmc_cpu_model (.mclk, .slow, .instr_done(cpu_instr_done),
    .sel_wr(idle_sel_wr | stop_sel_wr | suspend_sel_wr | sleep_sel_wr));
  // ****
  // helpers
  // ****
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // bounded: a stuck output ends the run instead of hanging it
  task automatic wt(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 30)
    begin
      cyc(1);
      n++;
    end
    chk(s, v);
    if (s !== v)
      test_done();
  endtask : wt
  task automatic sel(input int m);
    @(posedge mclk) {sleep_sel_wr, suspend_sel_wr, stop_sel_wr, idle_sel_wr} <= 4'h1 << m;
    @(posedge mclk) {sleep_sel_wr, suspend_sel_wr, stop_sel_wr, idle_sel_wr} <= 4'h0;
  endtask : sel
  // ****
  // scenarios
  // ****
  task automatic t_idle;
    sel(0);
    wt(cpu_halt, 1'b1);
    chk({idle_sel, precision_osc_en, periph_clk_en}, 10'h3ff);
    @(posedge mclk) int_pending <= 1'b1;
    cyc(2);
    chk({cpu_halt, idle_sel}, 2'b00);
    @(posedge mclk) int_pending <= 1'b0;
    $display("idle test done");
  endtask : t_idle
  task automatic t_stop;
    sel(1);
    wt(cpu_halt, 1'b1);
    chk({precision_osc_en, internal_osc_en}, 2'b01);
    @(posedge mclk) int_pending <= 1'b1;
    cyc(6);
    chk(cpu_halt, 1'b1);
    @(posedge mclk) {int_pending, reset_pin_n} <= 2'b00;
    wt(chip_reset, 1'b1);
    chk(fetch_addr_load, 16'h0000);
    @(posedge mclk) reset_pin_n <= 1'b1;
    wt(chip_reset, 1'b0);
    chk(cpu_halt, 1'b0);
    $display("stop test done");
  endtask : t_stop
  task automatic t_wake(input int m, input int b);
    @(posedge mclk) wake_enable <= 6'h00;
    sel(m);
    wt(cpu_halt, 1'b1);
    chk({sysclk_gate, internal_osc_en, core_regulator_en, ram_on_vdd}, m == 2 ? 4'b1010 : 4'b1001);
    @(posedge mclk) wake_event <= 6'h1f;
    cyc(6);
    chk(cpu_halt, 1'b1);
    @(posedge mclk) wake_enable <= 6'h01 << b;
    wt(cpu_halt, 1'b0);
    chk({chip_reset, internal_osc_en, core_regulator_en}, 3'b011);
    @(posedge mclk) wake_event <= 6'h00;
    $display("wake test done");
  endtask : t_wake
  task automatic t_lp;
    @(posedge mclk) {gate_wr, gate_wdata, periph_clk_req} <= {1'b1, 8'h05, 8'h04};
    @(posedge mclk) gate_wr <= 1'b0;
    cyc(2);
    chk({lp_active, periph_clk_en, sfr_access_en}, {1'b1, 8'hfe, 8'hfa});
    sel(0);
    wt(cpu_halt, 1'b1);
    @(posedge mclk) int_pending <= 1'b1;
    wt(cpu_halt, 1'b0);
    chk(lp_active, 1'b1);
    @(posedge mclk) {int_pending, gate_wr, gate_wdata} <= {2'b01, 8'h00};
    @(posedge mclk) gate_wr <= 1'b0;
    wt(lp_active, 1'b0);
    @(posedge mclk) {gate_wr, gate_wdata} <= {1'b1, 8'h05};
    @(posedge mclk) gate_wr <= 1'b0;
    sel(0);
    wt(cpu_halt, 1'b1);
    @(posedge mclk) internal_reset <= 1'b1;
    wt(chip_reset, 1'b1);
    @(posedge mclk) internal_reset <= 1'b0;
    wt(chip_reset, 1'b0);
    chk({cpu_halt, lp_active}, 2'b00);
    $display("low power test done");
  endtask : t_lp
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    wt(chip_reset, 1'b0);
    t_idle();
    t_stop();
    for (int b = 0; b < 5; b++)
      t_wake(2, b);
    @(posedge mclk) slow <= 1'b1;
    for (int b = 0; b < 4; b++)
      t_wake(3, b);
    t_lp();
    @(posedge mclk) supply_monitor_low <= 1'b1;
    wt(chip_reset, 1'b1);
    test_done();
  end
endmodule : tb
